// *** include/iid_pkg.sv ***
// package: register map, field layout, codes and carrier structs for the level controller
package iid_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam int          IID_AW          = 8;
	localparam logic [7:0]  IID_CTRL        = 8'h00;
	localparam logic [7:0]  IID_ENABLE      = 8'h04;
	localparam logic [7:0]  IID_REQUEST     = 8'h08;
	localparam logic [7:0]  IID_CAUSE       = 8'h0c;
	localparam logic [7:0]  IID_PREV        = 8'h10;
	localparam logic [7:0]  IID_PSTATUS     = 8'h14;
	localparam logic [7:0]  IID_ZFLAGS      = 8'h18;
	localparam logic [7:0]  IID_EXEC        = 8'h1c;
	localparam logic [7:0]  IID_ACC         = 8'h20;
	localparam logic [7:0]  IID_LEVEL       = 8'h24;
	localparam logic [7:0]  IID_SPC_BASE    = 8'h40;
	localparam logic [7:0]  IID_SPC_LAST    = 8'h7c;
	// ==========================================================
	// fields
	localparam int          IID_CTRL_ION    = 0;
	localparam int          IID_PS_PCINC    = 15;
	localparam int          IID_CAUSE_LOCK  = 8;
	localparam logic [3:0]  IID_INT_LEVEL   = 4'he;
	localparam int          IID_INT_BIT     = 14;
	// ==========================================================
	// cause codes
	localparam logic [3:0]  IID_C_NONE      = 4'h0;
	localparam logic [3:0]  IID_C_MONCALL   = 4'h1;
	localparam logic [3:0]  IID_C_PROT      = 4'h2;
	localparam logic [3:0]  IID_C_PAGE      = 4'h3;
	localparam logic [3:0]  IID_C_ZERR      = 4'h5;
	localparam logic [3:0]  IID_C_POWER     = 4'h8;
	// ==========================================================
	// returned read instruction: opcode [15:7], level [6:3], register [2:0]
	localparam logic [8:0]  IID_IRR_OPCODE  = 9'h1e0;
	localparam logic [2:0]  IID_REG_PC      = 3'h2;
	// ==========================================================
	// reset values and bus response codes
	localparam logic [15:0] IID_RST16       = 16'h0000;
	localparam logic [3:0]  IID_RST_LEVEL   = 4'h0;
	localparam logic [1:0]  IID_OKAY        = 2'h0;
	localparam logic [1:0]  IID_SLVERR      = 2'h2;

	typedef struct packed {
		logic             awvalid;
		logic [IID_AW-1:0] awaddr;
		logic             wvalid;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             bready;
		logic             arvalid;
		logic [IID_AW-1:0] araddr;
		logic             rready;
	} iid_axi_in_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} iid_axi_out_t;

	typedef struct packed {
		logic [15:0] pc;
		logic        int_event;
		logic [3:0]  int_code;
		logic        fetch_phase;
		logic        give_up;
		logic        z_set;
		logic [15:0] ext_req;
	} iid_cpu_in_t;

	typedef struct packed {
		logic [3:0]  current_level;
		logic [15:0] resume_pc;
		logic        level_switch;
		logic        int_taken;
	} iid_cpu_out_t;
endpackage

// *** logic/iid_ctrl.sv ***
// program level scheduler with internal interrupt identification, AXI4-Lite registers
//
// Summary of operation
// - internal interrupt forces level fourteen
// - latch cause code, lock against overwrite
// - reading cause returns code and unlocks
// - cause codes: call, protection, page, power
// - set error flag re-raises interrupt on re-entry
// - software raises level via enable and request
// - give-up saves counter after give-up instruction
// - previous level register keeps last level
// - previous level reads as read instruction
// - executing it returns offending saved counter
// - fetch violation leaves counter unincremented
// - paging status bit 15 shows increment
// - give-up clears own level request bit
// - internal interrupts need enable bit fourteen
// - reset clears request, enable and level
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
module iid_ctrl
(
	input  wire logic          clk,
	input  wire logic          rstn,
	input  iid_pkg::iid_axi_in_t  axi_in,
	output iid_pkg::iid_axi_out_t axi_out,
	input  iid_pkg::iid_cpu_in_t  cpu_in,
	output iid_pkg::iid_cpu_out_t cpu_out
);
	import iid_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic               awready;
		logic               wready;
		logic               aw_have;
		logic [IID_AW-1:0]  aw_addr;
		logic               w_have;
		logic [31:0]        w_data;
		logic [3:0]         w_strb;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               arready;
		logic               rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
		logic               ion;
		logic [15:0]        enable;
		logic [15:0]        request;
		logic [15:0]        zflag;
		logic [3:0]         level;
		logic [3:0]         prev;
		logic [3:0]         cause;
		logic               locked;
		logic               pc_inc;
		logic [15:0]        acc;
		logic               skip_save;
		logic [15:0][15:0]  spc;
		logic [15:0]        resume_pc;
		logic               level_switch;
		logic               int_taken;
	} iid_state_t;

	iid_state_t r;
	iid_state_t next_r;

	// ==========================================================
	// helpers
	function automatic logic [3:0] top_level(input logic [15:0] v);
		logic [3:0] t;
		t = IID_RST_LEVEL;
		for (int i = 0; i < 16; i++)
		begin
			if (v[i])
				t = 4'(i);
		end
		return t;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [15:0] m;
		m = old;
		if (s[0])
			m[7:0] = d[7:0];
		if (s[1])
			m[15:8] = d[15:8];
		return m;
	endfunction

	function automatic logic is_spc(input logic [IID_AW-1:0] a);
		return (a >= IID_SPC_BASE) && (a <= IID_SPC_LAST) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [3:0] spc_index(input logic [IID_AW-1:0] a);
		return a[5:2];
	endfunction

	// a give-up or a late violation resumes past the current instruction
	function automatic logic [15:0] pc_after(input logic [15:0] p);
		return p + 16'h0001;
	endfunction

	// only the saved counter is held here, other register selects read as zero
	function automatic logic [15:0] exec_value(input logic [15:0][15:0] spc,
		input logic [15:0] ins, input logic [15:0] acc);
		logic [15:0] v;
		v = acc;
		if (ins[15:7] == IID_IRR_OPCODE)
		begin
			if (ins[2:0] == IID_REG_PC)
				v = spc[ins[6:3]];
			else
				v = IID_RST16;
		end
		return v;
	endfunction

	function automatic logic mapped(input logic [IID_AW-1:0] a);
		logic m;
		case (a)
			IID_CTRL,
			IID_ENABLE,
			IID_REQUEST,
			IID_CAUSE,
			IID_PREV,
			IID_PSTATUS,
			IID_ZFLAGS,
			IID_EXEC,
			IID_ACC,
			IID_LEVEL:
				m = 1'b1;
			default:
				m = is_spc(a);
		endcase
		return m;
	endfunction

	// ==========================================================
	// next state
	always_comb
	begin
		logic [IID_AW-1:0] ra;
		logic [31:0]       rd;
		logic [3:0]        idx;
		logic [3:0]        tgt;
		logic              z_reentry;
		logic              take;
		logic [3:0]        code;

		next_r = r;
		next_r.level_switch = 1'b0;
		next_r.int_taken = 1'b0;
		// the give-up mark lives one cycle, so a later switch still saves
		next_r.skip_save = 1'b0;
		ra = axi_in.araddr;
		rd = 32'h0000_0000;
		idx = 4'h0;
		tgt = IID_RST_LEVEL;
		code = IID_C_NONE;

		// ==========================================================
		// write channel: address and data taken in either order
		if (r.awready && axi_in.awvalid)
		begin
			next_r.aw_have = 1'b1;
			next_r.aw_addr = axi_in.awaddr;
		end
		if (r.wready && axi_in.wvalid)
		begin
			next_r.w_have = 1'b1;
			next_r.w_data = axi_in.wdata;
			next_r.w_strb = axi_in.wstrb;
		end
		if (r.bvalid && axi_in.bready)
			next_r.bvalid = 1'b0;

		// ==========================================================
		// write apply: both halves held and no answer pending
		if (r.aw_have && r.w_have && !r.bvalid)
		begin
			next_r.aw_have = 1'b0;
			next_r.w_have = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = mapped(r.aw_addr) ? IID_OKAY : IID_SLVERR;
			idx = spc_index(r.aw_addr);
			case (r.aw_addr)
				IID_CTRL:
					if (r.w_strb[0])
						next_r.ion = r.w_data[IID_CTRL_ION];
				IID_ENABLE:
					next_r.enable = merge16(r.enable, r.w_data, r.w_strb);
				IID_REQUEST:
					next_r.request = merge16(r.request, r.w_data, r.w_strb);
				IID_ZFLAGS:
					// write one to clear; a flag raised in the same cycle still wins below
					next_r.zflag = r.zflag & ~merge16(16'h0000, r.w_data, r.w_strb);
				IID_EXEC:
					next_r.acc = exec_value(r.spc, r.w_data[15:0], r.acc);
				default:
					if (is_spc(r.aw_addr))
						next_r.spc[idx] = merge16(r.spc[idx], r.w_data, r.w_strb);
			endcase
		end

		// ==========================================================
		// read channel
		if (r.rvalid && axi_in.rready)
			next_r.rvalid = 1'b0;
		if (r.arready && axi_in.arvalid)
		begin
			case (ra)
				IID_CTRL:
					rd[IID_CTRL_ION] = r.ion;
				IID_ENABLE:
					rd[15:0] = r.enable;
				IID_REQUEST:
					rd[15:0] = r.request;
				IID_CAUSE:
				begin
					rd[3:0] = r.cause;
					rd[IID_CAUSE_LOCK] = r.locked;
					next_r.locked = 1'b0;
				end
				IID_PREV:
					rd[15:0] = {IID_IRR_OPCODE, r.prev, IID_REG_PC};
				IID_PSTATUS:
					rd[IID_PS_PCINC] = r.pc_inc;
				IID_ZFLAGS:
					rd[15:0] = r.zflag;
				IID_ACC:
					rd[15:0] = r.acc;
				IID_LEVEL:
					rd[3:0] = r.level;
				default:
					if (is_spc(ra))
						rd[15:0] = r.spc[spc_index(ra)];
			endcase
			next_r.rvalid = 1'b1;
			next_r.rdata = rd;
			next_r.rresp = mapped(ra) ? IID_OKAY : IID_SLVERR;
		end

		// ==========================================================
		// processor events; hardware sets win over software clears
		next_r.request = next_r.request | cpu_in.ext_req;
		if (cpu_in.z_set)
			next_r.zflag[r.level] = 1'b1;
		if (cpu_in.give_up)
		begin
			next_r.request[r.level] = 1'b0;
			next_r.spc[r.level] = pc_after(cpu_in.pc);
			next_r.skip_save = 1'b1;
		end

		// a flag left set re-raises as soon as its level runs again
		z_reentry = r.level_switch && r.zflag[r.level]
			&& (r.level != IID_INT_LEVEL);
		take = r.ion && r.enable[IID_INT_BIT]
			&& (cpu_in.int_event || z_reentry);
		// a reported event outranks the re-entry re-raise
		code = cpu_in.int_event ? cpu_in.int_code : IID_C_ZERR;

		// ==========================================================
		// level selection
		if (take)
		begin
			// set wins: a cause read in this cycle has already unlocked
			if (!next_r.locked)
			begin
				next_r.cause = code;
				next_r.locked = 1'b1;
			end
			if (cpu_in.int_event && cpu_in.fetch_phase)
			begin
				next_r.spc[r.level] = cpu_in.pc;
				next_r.pc_inc = 1'b0;
			end
			else
			begin
				next_r.spc[r.level] = pc_after(cpu_in.pc);
				next_r.pc_inc = 1'b1;
			end
			next_r.prev = r.level;
			next_r.level = IID_INT_LEVEL;
			next_r.request[IID_INT_BIT] = 1'b1;
			next_r.resume_pc = r.spc[IID_INT_LEVEL];
			next_r.level_switch = 1'b1;
			next_r.int_taken = 1'b1;
			next_r.skip_save = 1'b0;
		end
		else if (r.ion)
		begin
			tgt = top_level(r.enable & r.request);
			if (tgt != r.level)
			begin
				// a give-up already stored the counter past the give-up instruction
				if (!r.skip_save && !cpu_in.give_up)
					next_r.spc[r.level] = cpu_in.pc;
				next_r.prev = r.level;
				next_r.level = tgt;
				next_r.resume_pc = r.spc[tgt];
				next_r.level_switch = 1'b1;
				next_r.skip_save = 1'b0;
			end
		end

		// ==========================================================
		// readies drop while an answer waits, so one transfer of each kind is open
		next_r.awready = !next_r.aw_have && !next_r.bvalid;
		next_r.wready = !next_r.w_have && !next_r.bvalid;
		next_r.arready = !next_r.rvalid;
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			// readies start high so the first request after release is taken at once
			r <= '0;
			r.awready <= 1'b1;
			r.wready <= 1'b1;
			r.arready <= 1'b1;
		end
		else
			r <= next_r;
	end

	// ==========================================================
	// outputs, all straight from flops
	assign axi_out.awready = r.awready;
	assign axi_out.wready = r.wready;
	assign axi_out.bvalid = r.bvalid;
	assign axi_out.bresp = r.bresp;
	assign axi_out.arready = r.arready;
	assign axi_out.rvalid = r.rvalid;
	assign axi_out.rdata = r.rdata;
	assign axi_out.rresp = r.rresp;
	assign cpu_out.current_level = r.level;
	assign cpu_out.resume_pc = r.resume_pc;
	assign cpu_out.level_switch = r.level_switch;
	assign cpu_out.int_taken = r.int_taken;
endmodule

// *** dv/iid_chk.sv ***
// checker: bus handshakes and level switching at the controller ports
module iid_chk
(
	input wire logic            clk,
	input wire logic            rstn,
	input iid_pkg::iid_axi_in_t  axi_in,
	input iid_pkg::iid_axi_out_t axi_out,
	input iid_pkg::iid_cpu_in_t  cpu_in,
	input iid_pkg::iid_cpu_out_t cpu_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import iid_pkg::*;
	// ======
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_force;
		cpu_out.int_taken |-> cpu_out.level_switch && cpu_out.current_level == IID_INT_LEVEL
			&& ($past(cpu_in.int_event) || $past(cpu_out.level_switch));
	endproperty
	a_force: assert property (p_force) else $error("forced level wrong");
	property p_chg;
		$changed(cpu_out.current_level) |-> cpu_out.level_switch;
	endproperty
	a_chg: assert property (p_chg) else $error("level moved silently");
	property p_rst;
		$rose(rstn) |-> cpu_out.current_level == IID_RST_LEVEL && !cpu_out.level_switch;
	endproperty
	a_rst: assert property (p_rst) else $error("level not zero after reset");
	// a write answer must wait for the master
	property p_bhold;
		axi_out.bvalid && !axi_in.bready |=> axi_out.bvalid && $stable(axi_out.bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rhold;
		axi_out.rvalid && !axi_in.rready |=> axi_out.rvalid && $stable(axi_out.rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	property p_rans;
		axi_in.arvalid && axi_out.arready |=> axi_out.rvalid;
	endproperty
	a_rans: assert property (p_rans) else $error("read answer late");
	property p_bans;
		axi_in.awvalid && axi_out.awready && axi_in.wvalid && axi_out.wready |-> ##2 axi_out.bvalid;
	endproperty
	a_bans: assert property (p_bans) else $error("write answer late");
	property p_busy;
		axi_out.bvalid |-> !axi_out.awready && !axi_out.wready;
	endproperty
	a_busy: assert property (p_busy) else $error("second write taken");
endmodule

bind iid_ctrl iid_chk u_chk (.clk(clk), .rstn(rstn), .axi_in(axi_in),
	.axi_out(axi_out), .cpu_in(cpu_in), .cpu_out(cpu_out));

// *** dv/iid_cpu_model.sv ***
// partner: microprogram side reporting events and following level switches
module iid_cpu_model
(
	input wire logic             clk,
	input iid_pkg::iid_cpu_out_t cpu_out,
	output iid_pkg::iid_cpu_in_t cpu_in
);
	timeunit 1ns;
	timeprecision 1ns;
	import iid_pkg::*;
	logic [15:0] pc = 16'h0;
	logic [2:0]  kind = 3'h0;
	logic [3:0]  code = 4'h0;
	logic        fetch = 1'b0;
	assign cpu_in = {pc, kind[2], code, fetch, kind[1], kind[0], 16'h0};
	// counter restarts from the saved value of the level entered
	always @(posedge clk)
		if (cpu_out.level_switch)
			pc <= cpu_out.resume_pc;
	// one-cycle event; the code is scrambled after so a late sample shows
	task op(input logic [2:0] k, input logic [3:0] c, input logic f);
		kind <= k;
		code <= c;
		fetch <= f;
		@(posedge clk);
		kind <= 3'h0;
		code <= ~c;
		@(posedge clk);
	endtask
endmodule

// *** dv/tb_top.sv ***
// testbench: registers, level scheduling and internal interrupt identification
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import iid_pkg::*;
	typedef struct packed
	{
		logic [7:0]  a;
		logic [31:0] w;
		logic [31:0] e;
		logic [1:0]  r;
	} iid_row_t;
	logic         clk = 1'b0;
	logic         rstn = 1'b0;
	// answers are always accepted at once, so bready and rready stay high
	iid_axi_in_t  ai = '{wstrb: 4'hf, bready: 1'b1, rready: 1'b1, default: '0};
	iid_axi_out_t ao;
	iid_cpu_in_t  ci;
	iid_cpu_out_t co;
	int           fail_count = 0;
	int           checks_done = 0;
	int           cyc = 0;
	logic [31:0]  d;
	logic [1:0]   r;
	logic [15:0]  e;
	logic [31:0]  ins = {16'h0, IID_IRR_OPCODE, 4'h3, IID_REG_PC};
	logic [3:0]   codes [4] = '{IID_C_MONCALL, IID_C_PROT, IID_C_PAGE, IID_C_POWER};
	iid_row_t     rows [7] = '{
		'{IID_ENABLE, 32'hffff4008, 32'h4008, IID_OKAY},
		'{IID_SPC_BASE + 8'h0c, 32'h100, 32'h100, IID_OKAY},
		'{IID_LEVEL, 32'h5, 32'h0, IID_OKAY},
		'{IID_CAUSE, 32'h3, 32'h0, IID_OKAY},
		'{IID_PREV, 32'h0, 32'hf002, IID_OKAY},
		'{IID_PSTATUS, 32'hffff, 32'h0, IID_OKAY},
		'{8'h28, 32'h1, 32'h0, IID_SLVERR}};
	iid_ctrl dut (.clk(clk), .rstn(rstn), .axi_in(ai), .axi_out(ao), .cpu_in(ci), .cpu_out(co));
	iid_cpu_model m (.clk(clk), .cpu_out(co), .cpu_in(ci));
	always #10 clk = ~clk;
	// ======
	// tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] dw, output logic [1:0] rs);
		ai.awvalid <= 1'b1;
		ai.awaddr <= a;
		ai.wvalid <= 1'b1;
		ai.wdata <= dw;
		do
		begin
			@(posedge clk);
			if (ao.awready)
				ai.awvalid <= 1'b0;
			if (ao.wready)
				ai.wvalid <= 1'b0;
		end while (!ao.bvalid);
		rs = ao.bresp;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] dr, output logic [1:0] rs);
		ai.arvalid <= 1'b1;
		ai.araddr <= a;
		do
		begin
			@(posedge clk);
			if (ao.arready)
				ai.arvalid <= 1'b0;
		end while (!ao.rvalid);
		dr = ao.rdata;
		rs = ao.rresp;
	endtask
	task tally_and_finish;
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// a hang ends the run as a mismatch
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			fail_count++;
			tally_and_finish;
		end
	end
	// ======
	// sequence
	initial
	begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk(co.current_level, 0);
		rd(IID_REQUEST, d, r);
		chk(d, 0);
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].w, r);
			chk(r, rows[i].r);
			rd(rows[i].a, d, r);
			chk(d, rows[i].e);
			chk(r, rows[i].r);
		end
		wr(IID_REQUEST, 32'h8, r);
		wr(IID_CTRL, 32'h1, r);
		repeat (3) @(posedge clk);
		chk(co.current_level, 3);
		chk(co.resume_pc, 32'h100);
		e = m.pc + 16'h1;
		m.op(3'b100, IID_C_PROT, 1'b0);
		chk(co.current_level, IID_INT_LEVEL);
		rd(IID_PREV, d, r);
		chk(d, ins);
		rd(IID_SPC_BASE + 8'h0c, d, r);
		chk(d, {16'h0, e});
		wr(IID_EXEC, ins, r);
		rd(IID_ACC, d, r);
		chk(d, {16'h0, e});
		// locked cause must survive a second event
		m.op(3'b100, IID_C_PAGE, 1'b1);
		rd(IID_CAUSE, d, r);
		chk(d & 32'hf, IID_C_PROT);
		rd(IID_CAUSE, d, r);
		chk(d & 32'h100, 0);
		for (int i = 0; i < 4; i++)
		begin
			m.op(3'b100, codes[i], i[0]);
			rd(IID_CAUSE, d, r);
			chk(d & 32'hf, codes[i]);
			rd(IID_PSTATUS, d, r);
			chk(d, {16'h0, ~i[0], 15'h0});
		end
		e = m.pc + 16'h1;
		m.op(3'b010, 4'h0, 1'b0);
		repeat (2) @(posedge clk);
		chk(co.current_level, 3);
		rd(IID_REQUEST, d, r);
		chk(d, 32'h8);
		rd(IID_SPC_BASE + 8'h38, d, r);
		chk(d, {16'h0, e});
		// error flag on level 3 fires again on re-entry
		m.op(3'b001, 4'h0, 1'b0);
		m.op(3'b100, IID_C_MONCALL, 1'b0);
		rd(IID_CAUSE, d, r);
		m.op(3'b010, 4'h0, 1'b0);
		repeat (3) @(posedge clk);
		chk(co.current_level, IID_INT_LEVEL);
		rd(IID_CAUSE, d, r);
		chk(d & 32'hf, IID_C_ZERR);
		wr(IID_ZFLAGS, 32'h8, r);
		m.op(3'b010, 4'h0, 1'b0);
		repeat (3) @(posedge clk);
		chk(co.current_level, 3);
		wr(IID_ENABLE, 32'h8, r);
		m.op(3'b100, IID_C_PROT, 1'b0);
		chk(co.current_level, 3);
		rd(IID_CAUSE, d, r);
		chk(d, {28'h0, IID_C_ZERR});
		// reset in mid-run must clear masks and level again
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk(co.current_level, 32'h0);
		rd(IID_ENABLE, d, r);
		chk(d, 32'h0);
		rd(IID_REQUEST, d, r);
		chk(d, 32'h0);
		tally_and_finish;
	end
endmodule
